// >>> hdl/irq_prio.sv
// fixed-priority encoder for the channel interrupt sources
// assumes pend bit 0 is the most urgent source
`timescale 1ns/100ps
`default_nettype none
module irq_prio
	import uart_irq_pkg::*;
(
	irq_src_if.enc s // sources in, winner out
);

	// ---------------------------------------------------------------
	// lowest index wins; a lower source waits until it is on top
	// ---------------------------------------------------------------
	always_comb begin
		s.code = CODE_NONE;
		s.top  = 7'h00;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (s.pend[i]) begin
				s.code = SRC_CODE[i];
				s.top  = 7'(7'h01 << i);
			end
		end
	end

endmodule : irq_prio
`default_nettype wire

// >>> hdl/irq_src_if.sv
// carries pending sources to the priority encoder and its answer back
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
`default_nettype none
interface irq_src_if;
	logic [6:0] pend; // pending enabled sources
	logic [5:0] code; // status code of the winner
	logic [6:0] top;  // one-hot winner

	modport enc  (input pend, output code, output top);
	modport user (output pend, input code, input top);
endinterface : irq_src_if
`default_nettype wire

// >>> hdl/uart_chan_irq.sv
// interrupt enables, source flags and status register of one channel
// assumes fifo, line and modem logic run on clk; flow pins are async
//
// Functional notes
// R1 - rx data irq while level at trigger
// R2 - data ready set on push, clear empty
// R3 - line status bits report errors, empties
// R4 - low enables cleared gives polled mode; code still raises irq_r on wake_r
// R5 - cts rising edge interrupt when enabled
// R6 - rts rising edge interrupt when enabled
// R7 - xoff enable needs enhanced bit, off
// R8 - modem irq on any delta bit
// R9 - line irq on error, again at head
// R10 - tx irq below trigger and at empty
// R11 - non-fifo rx irq while holding full
// R12 - status shows only highest pending source
// R13 - timeout after four chars twelve bits
// R14 - flow char irq, cleared by status read
// R15 - flow pin irq only under auto flow
// R16 - each source cleared by its access
// R17 - wake flag set, cleared by global read
// R18 - status codes follow fixed priority table
// R19 - top status bits mirror fifo enable
// R20 - bits five, four need enhanced bit
// R21 - bit zero high when nothing pending
// R22 - one shared trigger table, default one
// R23 - sources reported to global registers
// R24 - fifo control needs enable bit set
// R25 - next source shown after clearing top
`timescale 1ns/100ps
`default_nettype none
module uart_chan_irq
	import uart_irq_pkg::*;
#(
	parameter int CHAR_BITS = CHAR_BITS_DEF // bits in one frame
) (
	input  wire logic       clk,         // 20 MHz bus clock
	input  wire logic       rstn,        // async reset
	input  wire logic [3:0] addr,        // register address
	input  wire logic [7:0] wdata,       // write data
	input  wire logic       wr,          // write strobe
	input  wire logic       rd,          // read strobe
	output logic      [7:0] rdata_r,     // read data, next cycle
	input  wire logic [7:0] rx_data,     // byte at fifo head
	input  wire logic [4:0] rx_level,    // rx fifo fill
	input  wire logic [4:0] tx_level,    // tx fifo fill
	input  wire logic       rx_push,     // char into rx fifo
	input  wire logic [3:0] rx_err,      // errors of pushed char
	input  wire logic [3:0] head_err,    // brk,frm,par,ovr at head
	input  wire logic       rx_fifo_err, // any errored char held
	input  wire logic       tsr_empty,   // shifter idle
	input  wire logic       bit_tick,    // one per bit time
	input  wire logic [7:0] msr_in,      // modem status value
	input  wire logic       xon_det,     // xon received
	input  wire logic       xoff_det,    // xoff received
	input  wire logic       spc_det,     // special char received
	input  wire logic       cts_pin,     // cts input pin
	input  wire logic       dsr_pin,     // dsr input pin
	input  wire logic       rts_lvl,     // rts output level
	input  wire logic       dtr_lvl,     // dtr output level
	input  wire logic       sleep_exit,  // left sleep mode
	input  wire logic       glob_rd,     // global word 0 read
	output logic            irq_r,       // channel interrupt
	output logic            wake_r,      // wake-up indication
	output logic      [6:0] src_r,       // enabled pending sources
	output logic            fifo_en_r,   // fifos enabled
	output logic      [4:0] rx_trig_r,   // rx trigger level
	output logic      [4:0] tx_trig_r,   // tx trigger level
	output logic            rx_rst_r,    // rx fifo reset pulse
	output logic            tx_rst_r,    // tx fifo reset pulse
	output logic            rhr_rd_r,    // holding read pulse
	output logic            thr_wr_r,    // holding write pulse
	output logic            msr_rd_r     // clears modem deltas
);

	localparam logic [7:0] TO_BITS = 8'(TO_CHARS * CHAR_BITS + TO_EXTRA);

	logic [7:0] ier_r, efr_r, mcr_r, feature_control_r;
	logic [7:0] to_cnt_r;
	logic [1:0] pin_s1, pin_s2;
	logic       in_prev_r, out_prev_r, head_prev_r;
	logic       below_prev_r, empty_prev_r;
	logic       ls_r, dr_r, to_r, tx_r, fc_r, spc_r, cts_r, rts_r;
	logic       enh, rd_isr, rd_lsr, rd_msr, rd_rhr, wr_thr, wr_fcr;
	logic       flow_in, flow_out, ls_set, to_hold, to_set, tx_set;
	logic       tx_below, tx_empty, rxd_lvl, fc_set, fc_clr;
	logic       isr_rd_top_tx, isr_rd_top_fc;
	logic [7:0] lsr_val;

	irq_src_if s ();

	irq_prio u_prio (
		.s (s.enc)
	);

	// ---------------------------------------------------------------
	// access decode
	// ---------------------------------------------------------------
	assign enh    = efr_r[EFR_ENH];
	assign rd_isr = rd && addr == A_ISR;
	assign rd_lsr = rd && addr == A_LSR;
	assign rd_msr = rd && addr == A_MSR;
	assign rd_rhr = rd && addr == A_RHR;
	assign wr_thr = wr && addr == A_RHR;
	assign wr_fcr = wr && addr == A_ISR;

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ier_r  <= REG_RST;
			efr_r  <= REG_RST;
			mcr_r  <= REG_RST;
			feature_control_r <= REG_RST;
		end else if (wr) begin
			// upper enables only take while enhanced mode is on
			if (addr == A_IER)
				ier_r <= {wdata[7:5] & {3{enh}}, 1'b0, wdata[3:0]}; // see R7
			if (addr == A_EFR)
				efr_r <= wdata;
			if (addr == A_MCR)
				mcr_r <= wdata;
			if (addr == A_FEATURE_CONTROL)
				feature_control_r <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fifo_en_r <= 1'b0;
			rx_trig_r <= TRIG_RST;
			tx_trig_r <= TRIG_RST;
			rx_rst_r  <= 1'b0;
			tx_rst_r  <= 1'b0;
		end else begin
			rx_rst_r <= 1'b0;
			tx_rst_r <= 1'b0;
			if (wr_fcr) begin
				fifo_en_r <= wdata[FCR_EN];
				if (wdata[FCR_EN]) begin // see R24
					rx_trig_r <= trig_level(wdata[7:6]); // see R22
					rx_rst_r  <= wdata[FCR_RXRST];
					tx_rst_r  <= wdata[FCR_TXRST];
					if (enh)
						tx_trig_r <= trig_level(wdata[5:4]); // see R22
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// flow pins: synchronise, then look for rising edges
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
		end else begin
			pin_s1 <= {dsr_pin, cts_pin};
			pin_s2 <= pin_s1;
		end
	end

	assign flow_in  = mcr_r[MCR_FSEL] ? pin_s2[1] : pin_s2[0];
	assign flow_out = mcr_r[MCR_FSEL] ? dtr_lvl : rts_lvl;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_prev_r  <= 1'b0;
			out_prev_r <= 1'b0;
			cts_r      <= 1'b0;
			rts_r      <= 1'b0;
		end else begin
			in_prev_r  <= flow_in;
			out_prev_r <= flow_out;
			// flags only arm under enhanced mode with auto flow on
			if (enh && efr_r[EFR_ACTS] && flow_in && !in_prev_r)
				cts_r <= 1'b1; // see R5 R15
			else if (rd_msr)
				cts_r <= 1'b0; // see R15
			if (enh && efr_r[EFR_ARTS] && flow_out && !out_prev_r)
				rts_r <= 1'b1; // see R6 R15
			else if (rd_msr)
				rts_r <= 1'b0; // see R15
		end
	end

	// ---------------------------------------------------------------
	// line status and receive data
	// ---------------------------------------------------------------
	assign ls_set = (rx_push && |rx_err) || (|head_err && !head_prev_r); // see R9
	assign rxd_lvl = fifo_en_r ? rx_level >= rx_trig_r // see R1
	                           : rx_level != 5'h00;    // see R11

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ls_r        <= 1'b0;
			head_prev_r <= 1'b0;
			dr_r        <= 1'b0;
		end else begin
			head_prev_r <= |head_err;
			if (ls_set)
				ls_r <= 1'b1;
			else if (rd_lsr)
				ls_r <= 1'b0; // see R16
			if (rx_push)
				dr_r <= 1'b1; // see R2
			else if (rx_level == 5'h00)
				dr_r <= 1'b0; // see R2
		end
	end

	assign lsr_val = {rx_fifo_err, tx_level == 5'h00 && tsr_empty,
	                  tx_level == 5'h00, head_err, dr_r}; // see R3

	// ---------------------------------------------------------------
	// receive timeout: restarts on every push or read
	// ---------------------------------------------------------------
	assign to_hold = rx_push || rd_rhr || rx_level == 5'h00 || !fifo_en_r;
	assign to_set  = !to_hold && bit_tick && to_cnt_r == TO_BITS - 8'h01;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			to_cnt_r <= 8'h00;
		else if (to_hold)
			to_cnt_r <= 8'h00;
		else if (bit_tick && to_cnt_r != TO_BITS)
			to_cnt_r <= to_cnt_r + 8'h01; // see R13
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			to_r <= 1'b0;
		else if (to_set)
			to_r <= 1'b1; // see R13
		else if (rd_rhr)
			to_r <= 1'b0; // see R13
	end

	// ---------------------------------------------------------------
	// transmit ready: below-trigger and empty events
	// ---------------------------------------------------------------
	assign tx_below = tx_level < tx_trig_r;
	// half-duplex mode with fifos enabled holds the empty event until the shifter is idle
	assign tx_empty = (fifo_en_r && feature_control_r[FEATURE_CONTROL_R485])
	                ? tx_level == 5'h00 && tsr_empty
	                : tx_level == 5'h00; // see R10
	assign tx_set = (fifo_en_r && tx_below && !below_prev_r)
	             || (tx_empty && !empty_prev_r); // see R10
	assign isr_rd_top_tx = rd_isr && s.top[SRC_TX];
	assign isr_rd_top_fc = rd_isr && s.top[SRC_FC];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			below_prev_r <= 1'b1;
			empty_prev_r <= 1'b1;
			tx_r         <= 1'b0;
		end else begin
			below_prev_r <= tx_below;
			empty_prev_r <= tx_empty;
			if (tx_set)
				tx_r <= 1'b1;
			else if (wr_thr || isr_rd_top_tx)
				tx_r <= 1'b0; // see R16
		end
	end

	// ---------------------------------------------------------------
	// flow and special characters
	// ---------------------------------------------------------------
	assign fc_set = xon_det || xoff_det || spc_det;
	assign fc_clr = isr_rd_top_fc || (spc_r && rx_push); // see R14

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fc_r  <= 1'b0;
			spc_r <= 1'b0;
		end else if (fc_set) begin
			fc_r  <= 1'b1; // see R14
			spc_r <= spc_det;
		end else if (fc_clr) begin
			fc_r  <= 1'b0; // see R14
			spc_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wake_r <= 1'b0;
		else if (sleep_exit)
			wake_r <= 1'b1; // see R17
		else if (glob_rd)
			wake_r <= 1'b0; // see R17
	end

	// ---------------------------------------------------------------
	// pending vector, status and interrupt
	// ---------------------------------------------------------------
	// all low enables cleared leaves polling of the status bits, but wake_r still drives irq_r
	// one driver for the whole vector; order is pin down to line
	assign s.pend = {
		enh && ((ier_r[IE_CTS] && cts_r)
		     || (ier_r[IE_RTS] && rts_r)), // see R20
		enh && ier_r[IE_XOFF] && fc_r,     // see R20
		ier_r[IE_MS] && |msr_in[3:0],      // see R8
		ier_r[IE_TXR] && tx_r,             // see R10
		ier_r[IE_RXD] && to_r,             // see R13
		ier_r[IE_RXD] && rxd_lvl,          // see R1 R4
		ier_r[IE_LS] && ls_r};             // see R4 R9

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_r <= 1'b0;
			src_r <= 7'h00;
		end else begin
			irq_r <= |s.pend || wake_r; // see R25
			src_r <= s.pend; // see R23
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else if (!rd) begin
			rdata_r <= 8'h00;
		end else begin
			unique case (addr)
				A_RHR:   rdata_r <= rx_data;
				A_IER:   rdata_r <= ier_r;
				A_ISR:   rdata_r <= {{2{fifo_en_r}}, s.code}; // see R12 R18 R19 R21
				A_MCR:   rdata_r <= mcr_r;
				A_LSR:   rdata_r <= lsr_val;
				A_MSR:   rdata_r <= msr_in;
				A_FEATURE_CONTROL:  rdata_r <= feature_control_r;
				A_EFR:   rdata_r <= efr_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rhr_rd_r <= 1'b0;
			thr_wr_r <= 1'b0;
			msr_rd_r <= 1'b0;
		end else begin
			rhr_rd_r <= rd_rhr;
			thr_wr_r <= wr_thr;
			msr_rd_r <= rd_msr; // see R16
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_rxd;
		fifo_en_r && ier_r[IE_RXD] && rx_level >= rx_trig_r |-> s.pend[SRC_RXD];
	endproperty
	a_rxd: assert property (p_rxd) else $error("rx level irq missing"); // see R1

	property p_dr;
		rx_push |=> dr_r;
	endproperty
	a_dr: assert property (p_dr) else $error("data ready not set"); // see R2

	property p_isr_read;
		rd_isr |=> rdata_r == {{2{$past(fifo_en_r)}}, $past(s.code)};
	endproperty
	a_isr_read: assert property (p_isr_read) else $error("bad status read"); // see R19

	property p_none;
		!(|s.pend) |-> s.code == CODE_NONE;
	endproperty
	a_none: assert property (p_none) else $error("idle code wrong"); // see R21

	property p_prio;
		s.pend[SRC_LS] |-> s.code == 6'h06;
	endproperty
	a_prio: assert property (p_prio) else $error("line status not top"); // see R18

	property p_to;
		to_set ##1 !rd_rhr[*2] |-> ##0 to_r;
	endproperty
	a_to: assert property (p_to) else $error("timeout flag lost"); // see R13

	property p_ls_clr;
		rd_lsr && !ls_set |=> !ls_r;
	endproperty
	a_ls_clr: assert property (p_ls_clr) else $error("lsr read kept flag"); // see R16

	property p_pin;
		enh && efr_r[EFR_ACTS] && $rose(flow_in) |=> cts_r;
	endproperty
	a_pin: assert property (p_pin) else $error("flow pin edge missed"); // see R15

	property p_irq;
		|s.pend |=> irq_r;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised"); // see R25

	property p_fcr;
		wr_fcr && !wdata[FCR_EN] |=> $stable(rx_trig_r) && !rx_rst_r;
	endproperty
	a_fcr: assert property (p_fcr) else $error("fcr took without enable"); // see R24

	property p_wake;
		sleep_exit |=> wake_r ##1 irq_r;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not flagged"); // see R17

endmodule : uart_chan_irq
`default_nettype wire

// >>> hdl/uart_irq_pkg.sv
// constants shared by the channel interrupt logic and its encoder
// assumes a 4-bit register address and 8-bit register data
package uart_irq_pkg;

	// --------------------------------------------------------------
	// register addresses
	// --------------------------------------------------------------
	localparam logic [3:0] A_RHR  = 4'h0;
	localparam logic [3:0] A_IER  = 4'h1;
	localparam logic [3:0] A_ISR  = 4'h2;
	localparam logic [3:0] A_MCR  = 4'h4;
	localparam logic [3:0] A_LSR  = 4'h5;
	localparam logic [3:0] A_MSR  = 4'h6;
	localparam logic [3:0] A_FEATURE_CONTROL = 4'h8;
	localparam logic [3:0] A_EFR  = 4'h9;

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int EFR_ENH   = 4;
	localparam int EFR_ARTS  = 6;
	localparam int EFR_ACTS  = 7;
	localparam int MCR_FSEL  = 2;
	localparam int FEATURE_CONTROL_R485 = 5;
	localparam int FCR_EN    = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int IE_RXD    = 0;
	localparam int IE_TXR    = 1;
	localparam int IE_LS     = 2;
	localparam int IE_MS     = 3;
	localparam int IE_XOFF   = 5;
	localparam int IE_RTS    = 6;
	localparam int IE_CTS    = 7;
	localparam logic [7:0] REG_RST = 8'h00;

	// --------------------------------------------------------------
	// sources, highest priority first, and their status codes
	// --------------------------------------------------------------
	localparam int NSRC    = 7;
	localparam int SRC_LS  = 0;
	localparam int SRC_RXD = 1;
	localparam int SRC_TO  = 2;
	localparam int SRC_TX  = 3;
	localparam int SRC_MS  = 4;
	localparam int SRC_FC  = 5;
	localparam int SRC_PIN = 6;
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [5:0] SRC_CODE [NSRC] = '{
		6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20};

	// --------------------------------------------------------------
	// trigger table and timeout figures
	// --------------------------------------------------------------
	localparam logic [4:0] TRIG_RST = 5'h01;
	localparam int CHAR_BITS_DEF = 10;
	localparam int TO_CHARS      = 4;
	localparam int TO_EXTRA      = 12;

	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'h0: trig_level = 5'h01;
			2'h1: trig_level = 5'h04;
			2'h2: trig_level = 5'h08;
			2'h3: trig_level = 5'h0E;
		endcase
	endfunction : trig_level

endpackage : uart_irq_pkg

// >>> test/host_bus.sv
// host processor model that owns the channel register port
// assumes the caller enters each task just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module host_bus (
	input  wire logic       clk,   // bus clock
	output logic      [3:0] addr,  // register address
	output logic      [7:0] wdata, // write data
	output logic            wr,    // write strobe
	output logic            rd,    // read strobe
	input  wire logic [7:0] rdata  // read data, cycle after rd
);
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one idle edge after each strobe keeps a strobe from being
	// dropped and raised again in one time step
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
		@(posedge clk);
	endtask : rd_reg
endmodule : host_bus
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the channel interrupt logic
// assumes host_bus owns the register port; other inputs driven here
`timescale 1ns/100ps
`default_nettype none
module testbench
	import uart_irq_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic       clk, rstn, rx_push, tsr_empty, bit_tick, irq, wake;
	logic       xon_det, xoff_det, spc_det, cts_pin, dsr_pin, fifo_en;
	logic       rts_lvl, dtr_lvl, sleep_exit, glob_rd, rx_fifo_err;
	logic       wr, rd;
	logic [3:0] addr, rx_err, head_err;
	logic [7:0] wdata, rdata, rx_data, msr_in, d;
	logic [4:0] rx_level, tx_level, rx_trig, tx_trig;
	logic [6:0] src;
	int         failures = 0;
	int         n_checks = 0;

	always #25 clk = ~clk;

	host_bus host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));

	// short frames keep the timeout at 4*2+12 = 20 bit ticks
	uart_chan_irq #(.CHAR_BITS(2)) dut_u (.clk(clk), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata),
		.rx_data(rx_data), .rx_level(rx_level), .tx_level(tx_level),
		.rx_push(rx_push), .rx_err(rx_err), .head_err(head_err),
		.rx_fifo_err(rx_fifo_err), .tsr_empty(tsr_empty),
		.bit_tick(bit_tick), .msr_in(msr_in), .xon_det(xon_det),
		.xoff_det(xoff_det), .spc_det(spc_det), .cts_pin(cts_pin),
		.dsr_pin(dsr_pin), .rts_lvl(rts_lvl), .dtr_lvl(dtr_lvl),
		.sleep_exit(sleep_exit), .glob_rd(glob_rd), .irq_r(irq),
		.wake_r(wake), .src_r(src), .fifo_en_r(fifo_en),
		.rx_trig_r(rx_trig), .tx_trig_r(tx_trig), .rx_rst_r(),
		.tx_rst_r(),
		.rhr_rd_r(), .thr_wr_r(), .msr_rd_r());

	// ----------------------------------------------------------------
	// check helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd_reg(a, v);
		chk(v, exp);
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#(4000 * 50);
		failures++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{clk, rx_push, tsr_empty, bit_tick, xon_det, xoff_det} = '0;
		{spc_det, cts_pin, dsr_pin, rts_lvl, dtr_lvl, rstn} = '0;
		{sleep_exit, glob_rd, rx_fifo_err, rx_err, head_err} = '0;
		{rx_level, msr_in} = '0;
		tx_level = 5'h02;
		rx_data = 8'h5A;
		cyc(4);
		rstn <= 1'b1;
		cyc(1);
		rchk(A_ISR, 8'h01);
		rchk(A_IER, 8'h00);
		chk({3'h0, rx_trig}, 8'h01);
		rchk(4'h3, 8'h00);
		$display("reset values done");

		host.wr_reg(A_IER, 8'hE0);
		rchk(A_IER, 8'h00);
		host.wr_reg(A_EFR, 8'h10);
		host.wr_reg(A_IER, 8'hE0);
		rchk(A_IER, 8'hE0);
		$display("enable gating done");

		host.wr_reg(A_IER, 8'h04);
		rx_push <= 1'b1;
		rx_err <= 4'h1;
		cyc(1);
		rx_push <= 1'b0;
		rx_err <= 4'h0;
		cyc(2);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk);
		rchk(A_ISR, 8'h06);
		host.rd_reg(A_LSR, d);
		rchk(A_ISR, 8'h01);
		$display("line status done");

		host.wr_reg(A_ISR, 8'hC1);
		chk({7'h00, fifo_en}, 8'h01);
		chk({3'h0, rx_trig}, 8'h0E);
		rchk(A_ISR, 8'hC1);
		host.wr_reg(A_ISR, 8'h40);
		chk({2'h0, fifo_en, rx_trig}, 8'h0E);
		rchk(A_ISR, 8'h01);
		host.wr_reg(A_ISR, 8'h71);
		chk({3'h0, rx_trig}, 8'h04);
		chk({3'h0, tx_trig}, 8'h0E);
		$display("fifo control done");

		host.wr_reg(A_IER, 8'h05);
		rx_level <= 5'h04;
		cyc(2);
		rchk(A_ISR, 8'hC4);
		rx_push <= 1'b1;
		rx_err <= 4'h4;
		cyc(1);
		rx_push <= 1'b0;
		rx_err <= 4'h0;
		cyc(2);
		@(negedge clk);
		chk({1'h0, src}, 8'h03);
		@(posedge clk);
		rchk(A_ISR, 8'hC6);
		host.rd_reg(A_LSR, d);
		rchk(A_ISR, 8'hC4);
		rx_level <= 5'h03;
		cyc(2);
		rchk(A_ISR, 8'hC1);
		$display("priority done");

		host.wr_reg(A_IER, 8'h01);
		bit_tick <= 1'b1;
		cyc(8);
		rchk(A_ISR, 8'hC1);
		cyc(20);
		rchk(A_ISR, 8'hCC);
		rchk(A_RHR, 8'h5A);
		bit_tick <= 1'b0;
		rchk(A_ISR, 8'hC1);
		$display("timeout done");

		host.wr_reg(A_IER, 8'h02);
		host.rd_reg(A_ISR, d);
		tsr_empty <= 1'b1;
		tx_level <= 5'h08;
		cyc(3);
		tx_level <= 5'h00;
		cyc(3);
		rchk(A_ISR, 8'hC2);
		rchk(A_ISR, 8'hC1);
		tx_level <= 5'h08;
		cyc(3);
		tx_level <= 5'h00;
		cyc(3);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk);
		host.wr_reg(A_RHR, 8'h33);
		cyc(1);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		@(posedge clk);
		$display("transmit ready done");

		host.wr_reg(A_IER, 8'h08);
		msr_in <= 8'h01;
		cyc(3);
		rchk(A_ISR, 8'hC0);
		rchk(A_MSR, 8'h01);
		msr_in <= 8'h00;
		cyc(2);
		rchk(A_ISR, 8'hC1);
		$display("modem status done");

		host.wr_reg(A_IER, 8'h20);
		xoff_det <= 1'b1;
		cyc(1);
		xoff_det <= 1'b0;
		cyc(2);
		rchk(A_ISR, 8'hD0);
		rchk(A_ISR, 8'hC1);
		xon_det <= 1'b1;
		cyc(1);
		xon_det <= 1'b0;
		cyc(2);
		rchk(A_ISR, 8'hD0);
		rchk(A_ISR, 8'hC1);
		spc_det <= 1'b1;
		cyc(1);
		spc_det <= 1'b0;
		rx_push <= 1'b1;
		cyc(1);
		rx_push <= 1'b0;
		cyc(2);
		rchk(A_ISR, 8'hC1);
		$display("flow character done");

		host.wr_reg(A_EFR, 8'hD0);
		host.wr_reg(A_IER, 8'h80);
		cts_pin <= 1'b1;
		cyc(5);
		rchk(A_ISR, 8'hE0);
		host.rd_reg(A_MSR, d);
		rchk(A_ISR, 8'hC1);
		host.wr_reg(A_IER, 8'h40);
		rts_lvl <= 1'b1;
		cyc(4);
		rchk(A_ISR, 8'hE0);
		host.rd_reg(A_MSR, d);
		rchk(A_ISR, 8'hC1);
		$display("flow pins done");

		sleep_exit <= 1'b1;
		cyc(1);
		sleep_exit <= 1'b0;
		cyc(2);
		@(negedge clk);
		chk({6'h00, wake, irq}, 8'h03);
		@(posedge clk);
		rchk(A_ISR, 8'hC1);
		glob_rd <= 1'b1;
		cyc(1);
		glob_rd <= 1'b0;
		cyc(2);
		@(negedge clk);
		chk({7'h00, wake}, 8'h00);
		@(posedge clk);
		$display("wake done");

		host.wr_reg(A_IER, 8'h00);
		rx_level <= 5'h04;
		rx_push <= 1'b1;
		rx_err <= 4'h1;
		cyc(1);
		rx_push <= 1'b0;
		rx_err <= 4'h0;
		cyc(3);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
		@(posedge clk);
		rchk(A_LSR, 8'h61);
		rx_level <= 5'h00;
		cyc(2);
		rchk(A_LSR, 8'h60);
		$display("polled mode done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
